// ==== design/pnfc_host.sv ====
// host side controller that runs read, program and erase sequences on the flash pins
`timescale 1ns/10ps
`default_nettype none
module pnfc_host
  import pnfc_pkg::*;
#(
  parameter int ERASE_TIMEOUT = ERASE_TIMEOUT_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_req_valid,
  input wire pnfc_op_e i_req_op,
  input wire logic [18:0] i_req_addr,
  input wire logic [15:0] i_req_data,
  output logic o_req_ready,
  output logic o_done,
  output logic o_error,
  output logic [15:0] o_rdata,
  output logic o_flash_ce_n,
  output logic o_flash_we_n,
  output logic o_flash_oe_n,
  output logic [18:0] o_flash_addr,
  output logic [15:0] o_flash_dq_out,
  output logic o_flash_dq_oe,
  input wire logic [15:0] i_flash_dq_in
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_WSETUP, ST_WLOW, ST_WHIGH, ST_READ, ST_POLL, ST_SETTLE, ST_DONE
  } pnfc_state_e;

  pnfc_state_e state_ff, nxt_state;
  pnfc_op_e op_ff, nxt_op;
  pnfc_bus_s bus_ff, nxt_bus;
  logic [2:0] step_ff, nxt_step;
  logic [21:0] cnt_ff, nxt_cnt;
  logic [21:0] wait_ff, nxt_wait;
  logic [18:0] addr_ff, nxt_addr;
  logic [15:0] data_ff, nxt_data;
  logic [15:0] rdata_ff, nxt_rdata;
  logic [15:0] prev_ff, nxt_prev;
  logic [1:0] conf_ff, nxt_conf;
  logic have_prev_ff, nxt_have_prev;
  logic done_ff, nxt_done;
  logic err_ff, nxt_err;
  logic [2:0] last_step;
  logic [18:0] cyc_addr;
  logic [15:0] cyc_data;
  logic poll_ok, stable;
  // sequence table: program 4 cycles, erase 6 cycles
  always_comb begin
    last_step = (op_ff == PNFC_OP_PROGRAM) ? 3'h3 : 3'h5;
    cyc_addr = UNLOCK_ADDR1;
    cyc_data = UNLOCK_CODE1;
    case (step_ff)
      3'h1, 3'h4: begin
        cyc_addr = UNLOCK_ADDR2;
        cyc_data = UNLOCK_CODE2;
      end
      3'h2: cyc_data = (op_ff == PNFC_OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE_SETUP;
      3'h3: begin
        if (op_ff == PNFC_OP_PROGRAM) begin
          cyc_addr = addr_ff;
          cyc_data = data_ff;
        end
      end
      3'h5: begin
        case (op_ff)
          PNFC_OP_SECTOR: begin
            cyc_addr = addr_ff;
            cyc_data = CMD_SECTOR_ERASE;
          end
          PNFC_OP_BLOCK: begin
            cyc_addr = addr_ff;
            cyc_data = CMD_BLOCK_ERASE;
          end
          default: cyc_data = CMD_CHIP_ERASE;
        endcase
      end
      default: ;
    endcase
  end
  // completion: polling bit true data (program) or one (erase), toggle bit still
  assign poll_ok = (op_ff == PNFC_OP_PROGRAM) ?
                   (i_flash_dq_in[POLL_BIT] == data_ff[POLL_BIT]) : i_flash_dq_in[POLL_BIT];
  assign stable = have_prev_ff && (i_flash_dq_in[TOGGLE_BIT] == prev_ff[TOGGLE_BIT]);
  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_bus = bus_ff;
    nxt_step = step_ff;
    nxt_cnt = cnt_ff;
    nxt_wait = wait_ff;
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_rdata = rdata_ff;
    nxt_prev = prev_ff;
    nxt_conf = conf_ff;
    nxt_have_prev = have_prev_ff;
    nxt_done = 1'b0;
    nxt_err = err_ff;
    case (state_ff)
      ST_IDLE: begin
        if (i_req_valid) begin
          nxt_op = i_req_op;
          nxt_addr = i_req_addr;
          nxt_data = i_req_data; // caller keeps the target erased, no check here
          nxt_step = 3'h0;
          nxt_cnt = 22'h0;
          nxt_err = 1'b0;
          if (i_req_op == PNFC_OP_READ) begin
            nxt_bus.addr = i_req_addr;
            nxt_bus.ce_n = 1'b0;
            nxt_bus.oe_n = 1'b0;
            nxt_bus.dq_oe = 1'b0;
            nxt_state = ST_READ;
          end else begin
            nxt_state = ST_WSETUP;
          end
        end
      end
      ST_WSETUP: begin
        // address and ce low set in the same cycle, then we low: address taken at we fall
        nxt_bus.addr = cyc_addr;
        nxt_bus.dout = cyc_data;
        nxt_bus.dq_oe = 1'b1;
        nxt_bus.oe_n = 1'b1;
        nxt_bus.ce_n = 1'b0;
        nxt_state = ST_WLOW;
      end
      ST_WLOW: begin
        nxt_bus.we_n = 1'b0;
        nxt_cnt = cnt_ff + 22'h1;
        if (cnt_ff == 22'(STROBE_CYC)) begin
          // we rises before ce so data is taken at we rise
          nxt_bus.we_n = 1'b1;
          nxt_cnt = 22'h0;
          nxt_state = ST_WHIGH;
        end
      end
      ST_WHIGH: begin
        nxt_bus.ce_n = 1'b1;
        nxt_bus.dq_oe = 1'b0;
        nxt_cnt = cnt_ff + 22'h1;
        if (cnt_ff == 22'(STROBE_CYC)) begin
          nxt_cnt = 22'h0;
          if (step_ff == last_step) begin
            // last rising strobe launched the internal operation
            nxt_wait = 22'h0;
            nxt_have_prev = 1'b0;
            nxt_conf = 2'h0;
            nxt_bus.addr = (op_ff == PNFC_OP_PROGRAM) ? addr_ff : cyc_addr;
            nxt_state = ST_POLL;
          end else begin
            nxt_step = step_ff + 3'h1;
            nxt_state = ST_WSETUP;
          end
        end
      end
      ST_READ, ST_POLL: begin
        nxt_bus.ce_n = 1'b0;
        nxt_bus.oe_n = 1'b0;
        nxt_bus.dq_oe = 1'b0;
        nxt_cnt = cnt_ff + 22'h1;
        nxt_wait = wait_ff + 22'h1;
        if (cnt_ff == 22'(READ_CYC)) begin
          // oe high between reads so each sample is a fresh read cycle
          nxt_bus.oe_n = 1'b1;
          nxt_cnt = 22'h0;
          nxt_rdata = i_flash_dq_in;
          if (state_ff == ST_READ) begin
            nxt_bus.ce_n = 1'b1;
            nxt_state = ST_DONE;
          end else begin
            nxt_prev = i_flash_dq_in;
            nxt_have_prev = 1'b1;
            // done only after two more agreeing reads, guards a race at completion
            if (poll_ok && stable) begin
              nxt_conf = conf_ff + 2'h1;
              if (conf_ff == 2'h2) begin
                nxt_state = ST_SETTLE;
              end
            end else begin
              nxt_conf = 2'h0;
            end
            if ((op_ff == PNFC_OP_PROGRAM && wait_ff >= 22'(PROG_MAX_CYC * 4)) ||
                wait_ff >= 22'(ERASE_TIMEOUT)) begin
              nxt_err = 1'b1;
              nxt_bus.ce_n = 1'b1;
              nxt_state = ST_DONE;
            end
          end
        end
      end
      ST_SETTLE: begin
        // remaining data bits may lag the polling bit, wait before next use
        nxt_bus.ce_n = 1'b1;
        nxt_bus.oe_n = 1'b1;
        nxt_cnt = cnt_ff + 22'h1;
        if (cnt_ff == 22'(SETTLE_CYC)) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_done = 1'b1;
        nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= ST_IDLE;
      op_ff <= PNFC_OP_READ;
      bus_ff <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dout: '0, dq_oe: 1'b0};
      step_ff <= 3'h0;
      cnt_ff <= 22'h0;
      wait_ff <= 22'h0;
      addr_ff <= 19'h0;
      data_ff <= 16'h0;
      rdata_ff <= 16'h0;
      prev_ff <= 16'h0;
      conf_ff <= 2'h0;
      have_prev_ff <= 1'b0;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
    end else if (i_ce) begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      bus_ff <= nxt_bus;
      step_ff <= nxt_step;
      cnt_ff <= nxt_cnt;
      wait_ff <= nxt_wait;
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      rdata_ff <= nxt_rdata;
      prev_ff <= nxt_prev;
      conf_ff <= nxt_conf;
      have_prev_ff <= nxt_have_prev;
      done_ff <= nxt_done;
      err_ff <= nxt_err;
    end
  end
  assign o_req_ready = (state_ff == ST_IDLE);
  assign o_done = done_ff;
  assign o_error = err_ff;
  assign o_rdata = rdata_ff;
  assign o_flash_ce_n = bus_ff.ce_n;
  assign o_flash_we_n = bus_ff.we_n;
  assign o_flash_oe_n = bus_ff.oe_n;
  assign o_flash_addr = bus_ff.addr;
  assign o_flash_dq_out = bus_ff.dout;
  assign o_flash_dq_oe = bus_ff.dq_oe;

  property p_we_only_with_ce;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      !o_flash_we_n |-> !o_flash_ce_n;
  endproperty
  a_we_only_with_ce: assert property (p_we_only_with_ce) else $error("we low without ce");
  property p_no_fight;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      !o_flash_oe_n |-> !o_flash_dq_oe && o_flash_we_n;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("host drives dq while oe low");
  property p_addr_stable_low;
    @(posedge i_core_clk) disable iff (!i_rst_n || !i_ce)
      (!o_flash_we_n && !$past(o_flash_we_n)) |-> $stable(o_flash_addr) && $stable(o_flash_dq_out);
  endproperty
  a_addr_stable_low: assert property (p_addr_stable_low) else $error("bus moved under we");
  property p_we_rises_first;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(o_flash_we_n) |-> !o_flash_ce_n && o_flash_dq_oe;
  endproperty
  a_we_rises_first: assert property (p_we_rises_first) else $error("ce rose before we");
  property p_done_pulse;
    @(posedge i_core_clk) disable iff (!i_rst_n || !i_ce)
      o_done |=> !o_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_ready_after_done;
    @(posedge i_core_clk) disable iff (!i_rst_n || !i_ce)
      o_done |=> o_req_ready;
  endproperty
  a_ready_after_done: assert property (p_ready_after_done) else $error("not ready after done");
  property p_seq_first_code;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (state_ff == ST_WLOW && step_ff == 3'h0) |->
        o_flash_addr == UNLOCK_ADDR1 && o_flash_dq_out == UNLOCK_CODE1;
  endproperty
  a_seq_first_code: assert property (p_seq_first_code) else $error("bad first unlock");
  property p_chip_last;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (state_ff == ST_WLOW && step_ff == 3'h5 && op_ff == PNFC_OP_CHIP) |->
        o_flash_addr == UNLOCK_ADDR1 && o_flash_dq_out == CMD_CHIP_ERASE;
  endproperty
  a_chip_last: assert property (p_chip_last) else $error("bad chip erase cycle");
endmodule
`default_nettype wire

// ==== design/pnfc_pkg.sv ====
// shared constants and types for the parallel nor flash command controller
// What this block does
// - address is taken when the later of write strobe and chip select falls
// - data is taken when the earlier of write strobe and chip select rises
// - host writes a command by pulsing write strobe low with chip select low
// - host programs a word without checking that its sector has been erased
// - program is three unlock cycles then one address and data cycle
// - sector erase is six cycles ending with code 30H at the sector address
// - block erase is six cycles ending with code 50H at the block address
// - chip erase is six cycles ending with code 10H at 5555H
// - on an agreeing status read the host reads twice more to confirm
package pnfc_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam logic [18:0] UNLOCK_ADDR1 = 19'h05555;
  localparam logic [18:0] UNLOCK_ADDR2 = 19'h02AAA;
  localparam logic [15:0] UNLOCK_CODE1 = 16'h00AA;
  localparam logic [15:0] UNLOCK_CODE2 = 16'h0055;
  localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
  localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [15:0] CMD_BLOCK_ERASE = 16'h0050;
  localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
  localparam int SECTOR_WORDS = 2048;
  localparam int BLOCK_WORDS = 32768;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int CLK_MHZ = 20;
  localparam int STROBE_CYC = 2;
  localparam int READ_CYC = 2;
  localparam int PROG_MAX_US = 20;
  localparam int PROG_MAX_CYC = PROG_MAX_US * CLK_MHZ;
  localparam int SETTLE_US = 1;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int ERASE_TIMEOUT_CYC = 4000000;
  typedef enum logic [2:0] {
    PNFC_OP_READ, PNFC_OP_PROGRAM, PNFC_OP_SECTOR, PNFC_OP_BLOCK, PNFC_OP_CHIP
  } pnfc_op_e;
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [18:0] addr;
    logic [15:0] dout;
    logic dq_oe;
  } pnfc_bus_s;
endpackage

// ==== test/pnfc_flash_model.sv ====
// behavioural flash device answering the host strobes
`timescale 1ns/10ps
`default_nettype none
module pnfc_flash_model
  import pnfc_pkg::*;
#(
  parameter int PROG_NS = 14000,
  parameter int ERASE_NS = 40000
) (
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic [18:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic i_stall,
  output logic [15:0] o_dq,
  output logic o_dq_oe
);
  logic [15:0] mem [int];
  logic [18:0] lat_a;
  logic [15:0] prog_d = 16'h0000;
  logic busy = 1'b0;
  logic erasing = 1'b0;
  logic settle = 1'b0;
  logic tog = 1'b0;
  logic wr_open = 1'b0;
  int step = 0;
  function automatic logic [15:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  task automatic run(input int ns, input logic er);
    busy = 1'b1;
    erasing = er;
    fork
      begin
        #(ns);
        // a stalled device overruns its limit, used to provoke the host timeout
        wait (!i_stall);
        busy = 1'b0;
        settle = 1'b1;
        #1000;
        settle = 1'b0;
      end
    join_none
  endtask
  task automatic wipe(input int a, input int n);
    for (int i = a & ~(n - 1); i <= (a | (n - 1)); i++) begin
      if (mem.exists(i)) mem.delete(i);
    end
    run(ERASE_NS, 1'b1);
  endtask
  task automatic cmd(input logic [18:0] a, input logic [15:0] d);
    if (busy) return;
    case (step)
      0, 3: step = (a == UNLOCK_ADDR1 && d == UNLOCK_CODE1) ? step + 1 : 0;
      1, 4: step = (a == UNLOCK_ADDR2 && d == UNLOCK_CODE2) ? step + 1 : 0;
      2: step = (a != UNLOCK_ADDR1) ? 0 : (d == CMD_PROGRAM) ? 6 : (d == CMD_ERASE_SETUP) ? 3 : 0;
      5: begin
        step = 0;
        if (d == CMD_SECTOR_ERASE) wipe(a, SECTOR_WORDS);
        else if (d == CMD_BLOCK_ERASE) wipe(a, BLOCK_WORDS);
        else if (d == CMD_CHIP_ERASE && a == UNLOCK_ADDR1) wipe(0, 1 << ADDR_W);
      end
      default: begin
        step = 0;
        prog_d = d;
        mem[a] = rd(a) & d;
        run(PROG_NS, 1'b0);
      end
    endcase
  endtask
  always @(negedge i_we_n or negedge i_ce_n) begin
    if (!i_we_n && !i_ce_n && i_oe_n) begin
      lat_a = i_addr;
      wr_open = 1'b1;
    end
  end
  always @(posedge i_we_n or posedge i_ce_n) begin
    if (wr_open) begin
      wr_open = 1'b0;
      cmd(lat_a, i_dq);
    end
  end
  always @(negedge i_oe_n or negedge i_ce_n) begin
    if (!i_oe_n && !i_ce_n && busy) tog = ~tog;
  end
  assign o_dq_oe = !i_ce_n && !i_oe_n;
  always @(i_addr or busy or tog or settle or erasing) begin
    // bits other than the polling and toggle bits stay wrong for a while after completion
    o_dq = rd(i_addr) ^ (settle ? 16'hFF3F : 16'h0000);
    if (busy) o_dq = {~o_dq[15:8], erasing ? 1'b0 : ~prog_d[7], tog, ~o_dq[5:0]};
  end
endmodule
`default_nettype wire

// ==== test/tb_parallel_nor_flash_command_control.sv ====
// self-checking bench for the flash command controller with a device model
`timescale 1ns/10ps
`default_nettype none
module tb_parallel_nor_flash_command_control
  import pnfc_pkg::*;
;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_ce = 1'b1;
  logic i_req_valid = 1'b0;
  pnfc_op_e i_req_op = PNFC_OP_READ;
  logic [18:0] i_req_addr = 19'h00000;
  logic [15:0] i_req_data = 16'h0000;
  logic stall = 1'b0;
  logic o_req_ready, o_done, o_error, o_flash_ce_n, o_flash_we_n, o_flash_oe_n;
  logic o_flash_dq_oe, mdl_oe;
  logic [18:0] o_flash_addr;
  logic [15:0] o_rdata, o_flash_dq_out, mdl_dq, dq_bus;
  logic [15:0] float_q = 16'hA5C3;
  logic [31:0] seed = 32'h468367B6;
  logic [31:0] bus_v;
  logic [15:0] rm [int];
  int errors = 0;
  int cmp_count = 0;
  always #25 i_core_clk = ~i_core_clk;
  // undriven bus shows a changing pattern, never the last value
  always @(posedge i_core_clk) float_q <= ~float_q;
  assign dq_bus = o_flash_dq_oe ? o_flash_dq_out : mdl_oe ? mdl_dq : float_q;
  assign bus_v = {10'h0, o_flash_ce_n, o_flash_we_n, o_flash_oe_n, o_flash_addr};
  pnfc_host #(.ERASE_TIMEOUT(2000)) dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_ce(i_ce), .i_req_valid(i_req_valid), .i_req_op(i_req_op), .i_req_addr(i_req_addr),
    .i_req_data(i_req_data), .o_req_ready(o_req_ready), .o_done(o_done), .o_error(o_error),
    .o_rdata(o_rdata), .o_flash_ce_n(o_flash_ce_n), .o_flash_we_n(o_flash_we_n),
    .o_flash_oe_n(o_flash_oe_n), .o_flash_addr(o_flash_addr), .o_flash_dq_out(o_flash_dq_out),
    .o_flash_dq_oe(o_flash_dq_oe), .i_flash_dq_in(dq_bus));
  pnfc_flash_model flash (.i_ce_n(o_flash_ce_n), .i_we_n(o_flash_we_n), .i_oe_n(o_flash_oe_n),
    .i_addr(o_flash_addr), .i_dq(dq_bus), .i_stall(stall), .o_dq(mdl_dq), .o_dq_oe(mdl_oe));
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] rexp(input int a);
    return rm.exists(a) ? rm[a] : 16'hFFFF;
  endfunction
  task automatic rwipe(input int a, input int n);
    for (int i = a & ~(n - 1); i <= (a | (n - 1)); i++) begin
      if (rm.exists(i)) rm.delete(i);
    end
  endtask
  task automatic op(input pnfc_op_e k, input logic [18:0] a, input logic [15:0] d);
    int n;
    logic [31:0] snap;
    n = 0;
    i_ce = 1'b1;
    // let the done cycle pass, a request only follows it
    @(negedge i_core_clk);
    while (o_req_ready !== 1'b1) @(negedge i_core_clk);
    i_req_valid = 1'b1;
    i_req_op = k;
    i_req_addr = a;
    i_req_data = d;
    @(negedge i_core_clk);
    i_req_valid = 1'b0;
    while (o_done !== 1'b1 && n < 8000) begin
      snap = bus_v;
      i_ce = (rnd() % 8) != 0;
      @(negedge i_core_clk);
      if (!i_ce) chk("freeze", snap, bus_v);
      n++;
    end
    i_ce = 1'b1;
    chk("done", 32'h1, {31'h0, o_done});
    chk("error", {31'h0, stall}, {31'h0, o_error});
    case (k)
      PNFC_OP_READ: chk("rdata", {16'h0, rexp(a)}, {16'h0, o_rdata});
      PNFC_OP_PROGRAM: rm[a] = rexp(a) & d;
      PNFC_OP_SECTOR: rwipe(a, SECTOR_WORDS);
      PNFC_OP_BLOCK: rwipe(a, BLOCK_WORDS);
      default: rm.delete();
    endcase
  endtask
  always @(negedge i_core_clk) begin
    if ((o_flash_dq_oe && mdl_oe) || (!o_flash_we_n && o_flash_ce_n)) begin
      errors++;
      $display("Error bus drive expected clean seen clash at %0t", $time);
    end
  end
  initial begin
    repeat (60000) @(posedge i_core_clk);
    errors++;
    end_of_test();
  end
  initial begin
    logic [18:0] a;
    repeat (2) @(negedge i_core_clk);
    chk("reset", 32'h78, {25'h0, o_req_ready, o_flash_ce_n, o_flash_we_n, o_flash_oe_n,
      o_flash_dq_oe, o_done, o_error});
    i_rst_n = 1'b1;
    op(PNFC_OP_CHIP, 19'h00000, 16'h0000);
    op(PNFC_OP_READ, 19'(rnd()), 16'h0000);
    for (int i = 0; i < 3; i++) begin
      a = 19'(rnd());
      op(PNFC_OP_PROGRAM, a, 16'(rnd()));
      op(PNFC_OP_READ, a, 16'h0000);
    end
    for (int k = 0; k < 2; k++) begin
      int n;
      n = k ? BLOCK_WORDS : SECTOR_WORDS;
      a = 19'(rnd());
      op(PNFC_OP_PROGRAM, a ^ 19'(n), 16'(rnd()));
      op(PNFC_OP_PROGRAM, a ^ 19'(n - 1), 16'(rnd()));
      op(k ? PNFC_OP_BLOCK : PNFC_OP_SECTOR, a, 16'h0000);
      op(PNFC_OP_READ, a ^ 19'(n), 16'h0000);
      op(PNFC_OP_READ, a ^ 19'(n - 1), 16'h0000);
    end
    stall = 1'b1;
    a = 19'(rnd());
    op(PNFC_OP_PROGRAM, a, 16'(rnd()));
    stall = 1'b0;
    repeat (SETTLE_CYC) @(negedge i_core_clk);
    op(PNFC_OP_READ, a, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
